// >>> hdl/sls_consts.svh
// Purpose: Offsets, field positions and reset values of the step sequencer
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Included by bare name from every design file that needs it
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH
// Register byte offsets
`define SLS_ADDR_CTRL      4'h0
`define SLS_ADDR_STATUS    4'h4
`define SLS_ADDR_ERR       4'h8
`define SLS_ADDR_BITCLR    4'hC
// Control register fields and reset value
`define SLS_CTRL_ENABLE    0
`define SLS_CTRL_RETAIN    1
`define SLS_CTRL_RST       2'h1
// Error register fields
`define SLS_ERR_DBL        0
`define SLS_ERR_WORD       1
// Status register fields
`define SLS_STAT_CUR_LSB   16
`define SLS_STAT_IN_SEC    20
`define SLS_STAT_START     21
`define SLS_STAT_STEP_ON   22
// Bit address at which the scan engine maps the step-start flag
`define SLS_START_FLAG_BIT 16'h0411
// Bus responses
`define SLS_RESP_OKAY      2'h0
`define SLS_RESP_SLVERR    2'h2
`endif

// >>> hdl/sls_pkg.sv
// Purpose: Types shared by the step sequencer files
// Assumes: Nothing beyond the constants header
// Notes:   Enums carry no explicit codes
package sls_pkg;
    // Instruction class presented by the scan engine
    typedef enum logic [2:0] {
        SLS_OP_NONE,
        SLS_OP_STEP_DEF,
        SLS_OP_STEP_END,
        SLS_OP_STEP_ADV,
        SLS_OP_COIL
    } sls_op_e;
    // Gating mode of the section being scanned
    typedef enum logic [1:0] {
        SLS_GATE_RUN,
        SLS_GATE_LOCK,
        SLS_GATE_SKIP
    } sls_gate_e;
endpackage

// >>> hdl/sls_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Register decode and read data come from the parent
// Notes:   Address and data of a write may arrive in either order
`timescale 1ns/1ps
`include "sls_consts.svh"
module sls_axil_slave import sls_pkg::*; #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Parent side
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_hit,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_hit
);
    logic              aw_got_ff;  // Write address held
    logic              w_got_ff;   // Write data held
    logic              bvalid_ff;  // Write response pending
    logic              rvalid_ff;  // Read response pending
    logic [ADDR_W-1:0] addr_ff;    // Held write address
    logic [31:0]       data_ff;    // Held write data
    logic [3:0]        strb_ff;    // Held byte enables
    logic [1:0]        bresp_ff;   // Write response code
    logic [1:0]        rresp_ff;   // Read response code
    logic [31:0]       rdata_ff;   // Read data

    // Handshake decode
    wire aw_take = awvalid && awready;
    wire w_take  = wvalid && wready;
    wire ar_take = arvalid && arready;
    wire do_wr   = aw_got_ff && w_got_ff && !bvalid_ff;

    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready  = !w_got_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;
    assign wr_en   = do_wr;
    assign wr_addr = addr_ff;
    assign wr_data = data_ff;
    assign wr_strb = strb_ff;
    assign rd_addr = araddr;

    // Write path: hold both halves, then commit and answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `SLS_RESP_OKAY;
            addr_ff   <= '0;
            data_ff   <= 32'h0;
            strb_ff   <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_got_ff <= 1'b1;
                addr_ff   <= awaddr;
            end
            if (w_take) begin
                w_got_ff <= 1'b1;
                data_ff  <= wdata;
                strb_ff  <= wstrb;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read path: capture decoded data on the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `SLS_RESP_OKAY;
            rdata_ff  <= 32'h0;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_hit ? rd_data : 32'h0;
            rresp_ff  <= rd_hit ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// >>> hdl/sls_sequencer.sv
// Purpose: Step-ladder sequencing logic beside a scan engine
// Assumes: Engine presents one instruction per cycle, top to bottom
// Notes:   Engine applies the gating outputs to the instructions it runs
`timescale 1ns/1ps
`include "sls_consts.svh"
module sls_sequencer import sls_pkg::*; #(
    parameter int ADDR_W = 4,
    parameter int NBITS  = 16,
    parameter int BIT_W  = 4,
    parameter int WORD_W = 6
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite register bus
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Scan engine instruction stream
    input  wire logic              scan_start,
    input  wire logic              instr_valid,
    input  sls_op_e                instr_op,
    input  wire logic [WORD_W-1:0] instr_word,
    input  wire logic [BIT_W-1:0]  instr_bit,
    input  wire logic              exec_cond,
    input  wire logic              power_restore,
    // Gating back to the scan engine
    output logic                   exec_en,
    output logic                   coil_force_off,
    output logic                   timer_reload,
    output logic                   count_hold,
    output logic                   step_start_flag,
    output logic [NBITS-1:0]       ctrl_bits
);
    logic [NBITS-1:0]  ctrl_ff;      // Step control bits
    logic [NBITS-1:0]  seen_ff;      // Bit value at last step define
    logic [NBITS-1:0]  step_use_ff;  // Bits used by step instr this scan
    logic [NBITS-1:0]  coil_use_ff;  // Bits used by coils this scan
    logic [WORD_W-1:0] word_ff;      // Word holding the control bits
    logic              word_set_ff;  // Word has been captured
    logic              in_sec_ff;    // Inside a step section
    sls_gate_e         mode_ff;      // Gating of the current section
    logic [BIT_W-1:0]  cur_bit_ff;   // Control bit of current section
    logic              start_ff;     // Step-start flag
    logic [1:0]        ctrl_reg_ff;  // Enable and retain settings
    logic              err_dbl_ff;   // Double output seen
    logic              err_word_ff;  // Control bits from two words
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic              wr_hit;       // Write address is writable
    logic              rd_hit;       // Read address is mapped
    logic [31:0]       rd_data;      // Decoded read data

    // Register bus front end
    sls_axil_slave #(.ADDR_W(ADDR_W)) sls_axil_slave_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wr_hit),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // Register decode
    wire sel_ctrl_w = wr_addr == `SLS_ADDR_CTRL;
    wire sel_err_w  = wr_addr == `SLS_ADDR_ERR;
    wire sel_clr_w  = wr_addr == `SLS_ADDR_BITCLR;
    assign wr_hit   = sel_ctrl_w || sel_err_w || sel_clr_w;
    wire rd_ctrl    = rd_addr == `SLS_ADDR_CTRL;
    wire rd_stat    = rd_addr == `SLS_ADDR_STATUS;
    wire rd_err     = rd_addr == `SLS_ADDR_ERR;
    wire rd_clr     = rd_addr == `SLS_ADDR_BITCLR;
    assign rd_hit   = rd_ctrl || rd_stat || rd_err || rd_clr;
    wire wr_ctrl    = wr_en && sel_ctrl_w && wr_strb[0];
    wire wr_err     = wr_en && sel_err_w && wr_strb[0];
    wire wr_clr     = wr_en && sel_clr_w;
    wire enable     = ctrl_reg_ff[`SLS_CTRL_ENABLE];
    wire retain     = ctrl_reg_ff[`SLS_CTRL_RETAIN];

    // Status word, unused bits read as zero
    wire [31:0] stat_w = {9'h0, (in_sec_ff && mode_ff == SLS_GATE_RUN),
                          start_ff, in_sec_ff, cur_bit_ff, ctrl_ff};
    assign rd_data = rd_ctrl ? {30'h0, ctrl_reg_ff} :
                     rd_stat ? stat_w :
                     rd_err  ? {30'h0, err_word_ff, err_dbl_ff} :
                     32'h0;

    // Instruction decode
    wire take     = instr_valid && enable;
    wire is_def   = take && instr_op == SLS_OP_STEP_DEF;
    wire is_end   = take && instr_op == SLS_OP_STEP_END;
    wire is_adv   = take && instr_op == SLS_OP_STEP_ADV;
    wire is_coil  = take && instr_op == SLS_OP_COIL;
    wire is_step  = is_def || is_adv;
    wire gate_on  = !in_sec_ff || mode_ff == SLS_GATE_RUN;
    wire [NBITS-1:0] hot = NBITS'(1) << instr_bit;
    wire [NBITS-1:0] cur_hot = (in_sec_ff && mode_ff == SLS_GATE_RUN) ?
                               NBITS'(1) << cur_bit_ff : '0;
    wire bit_on   = ctrl_ff[instr_bit];
    wire bit_was  = seen_ff[instr_bit];
    wire word_hit = instr_word == word_ff;

    wire adv_fire = is_adv && exec_cond && gate_on;
    wire [NBITS-1:0] adv_set = adv_fire ? hot : '0;
    wire [NBITS-1:0] adv_clr = adv_fire ? cur_hot : '0;
    // software turns a control bit off
    wire [NBITS-1:0] sw_clr = wr_clr ?
        {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & wr_data[NBITS-1:0] : '0;
    // non-retentive bits lost on power restore
    wire [NBITS-1:0] pwr_clr = (power_restore && !retain) ? '1 : '0;
    // A set in the same cycle as any clear wins
    wire [NBITS-1:0] nxt_ctrl = (ctrl_ff & ~(adv_clr | sw_clr | pwr_clr))
                                | adv_set;

    // section gating from current and previous bit
    wire sls_gate_e nxt_mode = bit_on  ? SLS_GATE_RUN :
                               bit_was ? SLS_GATE_LOCK : SLS_GATE_SKIP;

    // ordinary coil meets a step bit in either order, advances included
    wire dbl_set = word_set_ff && word_hit &&
                   ((is_coil && |(hot & step_use_ff)) ||
                    (is_step && |(hot & coil_use_ff)));
    // control bits must share one word
    wire word_set_err = is_step && word_set_ff && !word_hit;

    assign ctrl_bits       = ctrl_ff;
    assign step_start_flag = start_ff;
    assign exec_en         = gate_on;
    assign coil_force_off  = in_sec_ff && mode_ff == SLS_GATE_LOCK;
    assign timer_reload    = in_sec_ff && mode_ff == SLS_GATE_LOCK;
    // counters, shifters, latches hold when not running
    assign count_hold      = !gate_on;

    // Control bits and their last-seen copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= '0;
            seen_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            if (power_restore && !retain)
                seen_ff <= '0;
            else if (is_def)
                seen_ff[instr_bit] <= bit_on;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || scan_start) begin
            in_sec_ff  <= 1'b0;
            mode_ff    <= SLS_GATE_RUN;
            cur_bit_ff <= '0;
        end else if (is_def) begin
            in_sec_ff  <= 1'b1;
            mode_ff    <= nxt_mode;
            cur_bit_ff <= instr_bit;
        end else if (is_end) begin
            in_sec_ff  <= 1'b0;
            mode_ff    <= SLS_GATE_RUN;
        end
    end

    // start flag for the rest of this scan
    always_ff @(posedge aclk) begin
        if (!aresetn)
            start_ff <= 1'b0;
        else if (is_def && bit_on && !bit_was)
            start_ff <= 1'b1;
        else if (scan_start)
            start_ff <= 1'b0;
    end

    // Per-scan usage masks for the double output check
    always_ff @(posedge aclk) begin
        if (!aresetn || scan_start) begin
            step_use_ff <= '0;
            coil_use_ff <= '0;
        end else if (is_step && (word_hit || !word_set_ff)) begin
            step_use_ff <= step_use_ff | hot;
        end else if (is_coil && word_hit) begin
            coil_use_ff <= coil_use_ff | hot;
        end
    end

    // Word of the control bits, caught on first step instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_ff     <= '0;
            word_set_ff <= 1'b0;
        end else if (is_step && !word_set_ff) begin
            word_ff     <= instr_word;
            word_set_ff <= 1'b1;
        end
    end

    // Settings and sticky errors, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg_ff <= `SLS_CTRL_RST;
            err_dbl_ff  <= 1'b0;
            err_word_ff <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_reg_ff <= wr_data[1:0];
            if (dbl_set)
                err_dbl_ff <= 1'b1;
            else if (wr_err && wr_data[`SLS_ERR_DBL])
                err_dbl_ff <= 1'b0;
            if (word_set_err)
                err_word_ff <= 1'b1;
            else if (wr_err && wr_data[`SLS_ERR_WORD])
                err_word_ff <= 1'b0;
        end
    end

    // Checks on gating, start flag, double output and power loss
    adv_sets_bit_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        adv_fire |=> ctrl_ff[$past(instr_bit)])
        else $error("advance did not set its control bit");

    adv_ends_cur_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        adv_fire && cur_hot != '0 && cur_bit_ff != instr_bit
        |=> !ctrl_ff[$past(cur_bit_ff)])
        else $error("advance left the current step running");

    lock_on_drop_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_def && !bit_on && bit_was && !scan_start
        |=> coil_force_off && timer_reload && !exec_en)
        else $error("dropped step not interlocked");

    skip_when_off_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_def && !bit_on && !bit_was && !scan_start
        |=> !exec_en && !coil_force_off)
        else $error("idle step not skipped");

    run_when_on_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_def && bit_on |=> exec_en && !coil_force_off)
        else $error("active step not executing");

    keep_counters_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        coil_force_off |-> count_hold && !exec_en)
        else $error("counters not held on completion");

    end_stepping_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_end |=> exec_en && !in_sec_ff)
        else $error("stepping did not end");

    start_flag_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(start_ff) |-> $past(is_def && bit_on && !bit_was))
        else $error("start flag without a step start");

    start_one_scan_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        scan_start && !is_def |=> !start_ff)
        else $error("start flag outlived its scan");

    branch_no_err_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_adv && (hot & coil_use_ff) == '0 && !err_dbl_ff
        |=> !err_dbl_ff)
        else $error("branch flagged as double output");

    dbl_out_err_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        is_coil && word_set_ff && word_hit && |(hot & step_use_ff)
        |=> err_dbl_ff)
        else $error("double output not flagged");

    power_lose_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        power_restore && !retain && !adv_fire |=> ctrl_ff == '0)
        else $error("non-retentive bits survived power");
endmodule

// >>> sim/step_ladder_sequencer_bench.sv
// Purpose: Self-checking bench for the step sequencer
// Assumes: Bus and scan timing as the hand-over contract gives them
// Notes:   Drivers queue expected notes, a monitor compares results
`timescale 1ns/1ps
`include "sls_consts.svh"
module step_ladder_sequencer_bench import sls_pkg::*;;
    // Expected result and the bits that matter
    typedef struct packed {
        logic [31:0] v;
        logic [31:0] m;
    } sls_note_s;
    sls_note_s   q[$];          // Oldest note first
    sls_note_s   note;          // Note being compared
    logic [31:0] got;           // Observed value
    logic        rd_seen;       // Read answer taken this edge
    logic        wr_seen;       // Write answer taken this edge
    int          errors;        // Mismatch count
    int          check_count;   // Comparison count
    logic [31:0] seed;          // Random state
    logic [15:0] bits;          // Expected control bits
    logic        aclk, aresetn, gate_chk;
    logic [3:0]  awaddr, araddr, wstrb, instr_bit;
    logic [31:0] wdata, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        scan_start, instr_valid, exec_cond, power_restore;
    sls_op_e     instr_op;
    logic [5:0]  instr_word;
    logic        exec_en, coil_force_off, timer_reload, count_hold;
    logic        step_start_flag;
    logic [15:0] ctrl_bits;

    // Device under test
    sls_sequencer sls_sequencer_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .scan_start(scan_start), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_word(instr_word),
        .instr_bit(instr_bit), .exec_cond(exec_cond),
        .power_restore(power_restore), .exec_en(exec_en),
        .coil_force_off(coil_force_off), .timer_reload(timer_reload),
        .count_hold(count_hold), .step_start_flag(step_start_flag),
        .ctrl_bits(ctrl_bits)
    );

    // Clock at 50 MHz
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Ends the run with the verdict
    task print_verdict;
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A wait ran out of its bound
    task timeout;
        errors++;
        print_verdict();
    endtask

    // Xorshift step for random values
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Write one register and expect answer r, OKAY by default
    task wr(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] r = 2'h0);
        int   n;
        logic dn;
        dn = 1'b0;
        q.push_back('{{30'h0, r}, 32'h3});
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100 && !dn; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                dn = 1'b1;
                bready <= 1'b0;
            end
        end
        if (!dn) timeout();
    endtask

    // Read one register, expecting v under mask m
    task rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m);
        int   n;
        logic dn;
        dn = 1'b0;
        q.push_back('{v, m});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100 && !dn; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                dn = 1'b1;
                rready <= 1'b0;
            end
        end
        if (!dn) timeout();
    endtask

    // Present one instruction to the sequencer
    task ins(input sls_op_e op, input logic [3:0] b, input logic c = 1'b1,
             input logic [5:0] w = 6'h0);
        @(posedge aclk);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_bit   <= b;
        exec_cond   <= c;
        instr_word  <= w;
    endtask

    // Expect gating {run,lock,reload,hold,start} and control bits
    task gchk(input logic [20:0] v);
        @(posedge aclk);
        instr_valid <= 1'b0;
        q.push_back('{{11'h0, v}, 32'h1FFFFF});
        gate_chk <= 1'b1;
        @(posedge aclk);
        gate_chk <= 1'b0;
    endtask

    // One-cycle pulse on a strobe input
    task scan;
        @(posedge aclk);
        instr_valid <= 1'b0;
        scan_start  <= 1'b1;
        @(posedge aclk);
        scan_start  <= 1'b0;
    endtask
    task pwr;
        @(posedge aclk);
        power_restore <= 1'b1;
        @(posedge aclk);
        power_restore <= 1'b0;
    endtask

    // Monitor takes the oldest note whenever a result appears
    always @(posedge aclk) begin
        rd_seen = rvalid && rready;
        wr_seen = bvalid && bready;
        // Every read targets a mapped register, so OKAY is due
        if (aresetn && rd_seen) begin
            check_count++;
            if (rresp !== `SLS_RESP_OKAY) begin
                errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, rresp, 2'h0);
            end
        end
        if (aresetn && (rd_seen || wr_seen || gate_chk)) begin
            got = rd_seen ? rdata : wr_seen ? {30'h0, bresp}
                : {11'h0, exec_en, coil_force_off, timer_reload, count_hold,
                   step_start_flag, ctrl_bits};
            note = (q.size() > 0) ? q.pop_front() : '{32'hDEAD, 32'hFFFFFFFF};
            check_count++;
            if ((got & note.m) !== (note.v & note.m)) begin
                errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, note.v);
            end
        end
    end

    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, gate_chk} = 6'h0;
        {scan_start, instr_valid, exec_cond, power_restore} = 4'h0;
        {awaddr, araddr, instr_bit, instr_word} = 18'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        instr_op = SLS_OP_NONE;
        errors = 0;
        check_count = 0;
        seed = 32'h3A;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SLS_ADDR_CTRL, 32'h1, 32'hFFFFFFFF);
        rd(`SLS_ADDR_BITCLR, 32'h0, 32'hFFFFFFFF);
        scan();
        ins(SLS_OP_STEP_ADV, 4'h0);
        ins(SLS_OP_STEP_DEF, 4'h0);
        gchk({5'b10001, 16'h0001});
        ins(SLS_OP_STEP_ADV, 4'h1);
        gchk({5'b10001, 16'h0002});
        ins(SLS_OP_STEP_ADV, 4'h2, 1'b0);
        gchk({5'b10001, 16'h0002});
        ins(SLS_OP_STEP_DEF, 4'h1);
        gchk({5'b10001, 16'h0002});
        ins(SLS_OP_STEP_END, 4'h0);
        gchk({5'b10001, 16'h0002});
        scan();
        ins(SLS_OP_STEP_DEF, 4'h0);
        gchk({5'b01110, 16'h0002});
        ins(SLS_OP_STEP_ADV, 4'h3);
        gchk({5'b01110, 16'h0002});
        ins(SLS_OP_STEP_DEF, 4'h1);
        gchk({5'b10000, 16'h0002});
        ins(SLS_OP_STEP_END, 4'h0);
        scan();
        ins(SLS_OP_STEP_DEF, 4'h0);
        gchk({5'b00010, 16'h0002});
        ins(SLS_OP_STEP_END, 4'h0);
        scan();
        ins(SLS_OP_STEP_ADV, 4'h4);
        ins(SLS_OP_STEP_ADV, 4'h5);
        ins(SLS_OP_STEP_DEF, 4'h4);
        ins(SLS_OP_STEP_ADV, 4'h6);
        ins(SLS_OP_STEP_DEF, 4'h5);
        ins(SLS_OP_STEP_ADV, 4'h6);
        ins(SLS_OP_STEP_END, 4'h0);
        gchk({5'b10001, 16'h0042});
        scan();
        rd(`SLS_ADDR_ERR, 32'h0, 32'h3);
        ins(SLS_OP_STEP_ADV, 4'h6, 1'b0);
        ins(SLS_OP_COIL, 4'h6);
        ins(SLS_OP_STEP_END, 4'h0);
        scan();
        rd(`SLS_ADDR_ERR, 32'h1, 32'h1);
        wr(`SLS_ADDR_ERR, 32'h1);
        rd(`SLS_ADDR_ERR, 32'h0, 32'h1);
        ins(SLS_OP_STEP_DEF, 4'hF, 1'b1, 6'h1);
        ins(SLS_OP_STEP_END, 4'h0);
        scan();
        rd(`SLS_ADDR_ERR, 32'h2, 32'h2);
        bits = 16'h0042;
        repeat (4) begin
            seed = xs(seed);
            ins(SLS_OP_STEP_ADV, seed[3:0]);
            bits = bits | (16'h1 << seed[3:0]);
        end
        ins(SLS_OP_STEP_END, 4'h0);
        rd(`SLS_ADDR_STATUS, {16'h0, bits}, 32'hFFFF);
        seed = xs(seed);
        wr(`SLS_ADDR_BITCLR, seed);
        bits = bits & ~seed[15:0];
        rd(`SLS_ADDR_STATUS, {16'h0, bits}, 32'hFFFF);
        wr(`SLS_ADDR_STATUS, 32'hFFFF, `SLS_RESP_SLVERR);
        wr(`SLS_ADDR_CTRL, 32'h3);
        rd(`SLS_ADDR_CTRL, 32'h3, 32'h3);
        pwr();
        rd(`SLS_ADDR_STATUS, {16'h0, bits}, 32'hFFFF);
        wr(`SLS_ADDR_CTRL, 32'h1);
        pwr();
        rd(`SLS_ADDR_STATUS, 32'h0, 32'hFFFF);
        repeat (4) @(posedge aclk);
        print_verdict();
    end
endmodule
